// file: reset_seq_checker.sv
// Port-level checks for the reset source sequencer.
`timescale 1ns/1ns
module reset_seq_checker
   import rst_seq_pkg::*;
#(
   parameter int SETTLE_COUNT = 20,
   parameter int BOR_HOLD_COUNT = 16
)
(
   // Clock and reset.
   input wire logic SYS_CLK,
   input wire logic NRST,
   // Monitors.
   input wire logic EXT_RST_N,
   input wire logic POR_DET,
   input wire logic BOR_DET,
   input wire logic REG_LOSS,
   // Register port.
   input wire logic [11:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [31:0] REG_RDATA,
   // Outputs.
   input wire logic SYS_RST_N,
   input wire logic TAP_RST_N,
   input wire logic [SOFT_REGS*SOFT_W-1:0] PERIPH_RST_N,
   input wire logic [1:0] FETCH_STEP,
   input wire logic [3:0] REG_TRIM,
   input wire logic IRQ
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);
   int settle_q;
   logic pin_seq_q;
   // Low cycles of system reset since pin and power-on both let go.
   always_ff @(posedge SYS_CLK) begin
      if (!NRST || !EXT_RST_N || POR_DET || SYS_RST_N) begin
         settle_q <= 0;
      end else begin
         settle_q <= settle_q + 1;
      end
   end
   // Marks a sequence started by the pin or power-on, not internal.
   always_ff @(posedge SYS_CLK) begin
      if (!NRST || !EXT_RST_N || POR_DET) begin
         pin_seq_q <= 1'b1;
      end else if (SYS_RST_N) begin
         pin_seq_q <= 1'b0;
      end
   end
   chk_tap_spared: assert property (TAP_RST_N |=> TAP_RST_N)
      else $error("test port reset fell");
   chk_fetch_order: assert property ($rose(SYS_RST_N) |->
      FETCH_STEP == FETCH_SP ##1 FETCH_STEP == FETCH_PC ##1
      FETCH_STEP == FETCH_INSN ##1 FETCH_STEP == FETCH_NONE)
      else $error("bad fetch order");
   chk_fetch_released: assert property (
      FETCH_STEP != FETCH_NONE |-> SYS_RST_N)
      else $error("fetch while in reset");
   chk_settle_span: assert property (
      $rose(SYS_RST_N) && pin_seq_q |->
      settle_q >= SETTLE_COUNT && settle_q <= SETTLE_COUNT + 12)
      else $error("settle span wrong");
   chk_rdata_idle: assert property (
      !$past(REG_RD) |-> REG_RDATA == 32'h0000_0000)
      else $error("read data outside slot");
   chk_trim_range: assert property (REG_TRIM <= TRIM_MAX)
      else $error("trim out of range");
   chk_pin_reset: assert property (
      !EXT_RST_N |-> ##[1:4] !SYS_RST_N)
      else $error("pin reset late");
   chk_sysreq_reset: assert property (
      REG_WR && REG_ADDR == OFS_SYS_REQ && REG_WDATA[SYS_REQ_BIT]
      && SYS_RST_N |-> ##[1:3] (!SYS_RST_N) [*4])
      else $error("system request ignored");
   chk_soft_level: assert property (
      REG_WR && REG_ADDR == OFS_SOFT_RST1 && SYS_RST_N |-> ##2
      PERIPH_RST_N[2*SOFT_W-1:SOFT_W] == ~$past(REG_WDATA, 2))
      else $error("unit reset mismatch");
   cover property ($rose(SYS_RST_N) && pin_seq_q);
   cover property (REG_WR && REG_ADDR == OFS_SYS_REQ);
   cover property ($rose(IRQ));
endmodule

// file: reset_source_sequencer.sv
// Reset source gathering, cause recording and internal reset release.
// Functional notes
// - Six reset sources each start a sequence.
// - Cause flag set per source, sticky.
// - External pin cause clears all other flags.
// - Pin reset spares the test port controller.
// - Settle count runs after pin release.
// - Power-up waits for pin and power-on.
// - Release fetches stack, counter, then instruction.
// - Power-on reset only on first power-up.
// - Brown-out gives interrupt or reset by configuration.
// - Brown-out reset only when enabled; starts disabled.
// - Optional resample after delay before acting.
// - Brown-out held 500 us before release; code releases after the 320 ns internal hold.
// - Writing one resets the chosen peripheral.
// - Soft reset bits match clock gating bits.
// - System reset request resets whole system.
// - Watchdog interrupts, then resets on second time-out.
// - Regulator loss resets when enabled; starts disabled.
// - Trim selects 2.25 to 2.75 V, 50 mV steps.
`timescale 1ns/1ns
module reset_source_sequencer
   import rst_seq_pkg::*;
#(
   parameter int SETTLE_COUNT = SETTLE_CYCLES,
   parameter int BOR_HOLD_COUNT = BOR_HOLD_CYCLES
)
(
   // Clock and always-on reset.
   input wire logic SYS_CLK,
   input wire logic NRST,
   // Pin and supply monitors, asynchronous.
   input wire logic EXT_RST_N,
   input wire logic POR_DET,
   input wire logic BOR_DET,
   input wire logic REG_LOSS,
   // Register port.
   input wire logic [11:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   // Reset, boot, trim and interrupt outputs.
   output logic SYS_RST_N,
   output logic TAP_RST_N,
   output logic [SOFT_REGS*SOFT_W-1:0] PERIPH_RST_N,
   output logic [1:0] FETCH_STEP,
   output logic [3:0] REG_TRIM,
   output logic IRQ
);
   localparam logic [19:0] SETTLE_LAST = 20'(SETTLE_COUNT - 1);
   localparam logic [15:0] BOR_HOLD_LAST = 16'(BOR_HOLD_COUNT - 1);
   localparam logic [19:0] INT_HOLD_LAST = 20'(INT_HOLD_CYCLES - 1);

   // Clear-on-write-one with set priority.
   function automatic logic [7:0] w1c(input logic [7:0] cur,
                                      input logic [7:0] clr,
                                      input logic [7:0] set);
      w1c = (cur & ~clr) | set;
   endfunction

   // Keep the trim code inside the documented voltage span.
   function automatic logic [3:0] clamp_trim(input logic [3:0] code);
      clamp_trim = (code > TRIM_MAX) ? TRIM_MAX : code;
   endfunction

   logic [3:0] meta_q;
   logic [3:0] sync_q;
   seq_state_type state_q;
   logic [19:0] cnt_q;
   logic por_done_q;
   logic rst_n_q;
   logic tap_rst_n_q;
   logic [1:0] fetch_q;
   bo_state_type bo_q;
   logic [15:0] bo_cnt_q;
   logic [31:0] bo_ctrl_q;
   logic [31:0] reg_ctrl_q;
   logic [SOFT_REGS*SOFT_W-1:0] soft_q;
   logic [SOFT_REGS*SOFT_W-1:0] periph_q;
   logic sys_req_q;
   logic [IRQ_W-1:0] irq_st_q;
   logic [IRQ_W-1:0] irq_mask_q;
   logic irq_q;
   logic [CAUSE_W-1:0] cause_q;
   logic [31:0] wdt_load_q;
   logic [1:0] wdt_ctrl_q;
   logic reg_loss_q;
   logic wdt_int_q;
   logic [31:0] rdata_q;
   logic ext_on;
   logic por_on;
   logic bor_in;
   logic bo_act;
   logic bor_rst;
   logic reg_rst;
   logic int_req;
   logic taking;
   logic [CAUSE_W-1:0] cause_set;
   logic [IRQ_W-1:0] irq_evt;
   logic [7:0] cause_d;
   logic [7:0] irq_d;
   logic wr_cause;
   logic wr_irq;
   wdt_ctl_if wdt_bus ();

   wdt_core u_wdt (
      .clk(SYS_CLK),
      .nrst(NRST),
      .hold(~rst_n_q),
      .ctl(wdt_bus.wdt)
   );

   // Watchdog register fields steer the counter.
   assign wdt_bus.load_val = REG_WDATA;
   assign wdt_bus.load_wr = REG_WR && (REG_ADDR == OFS_WDT_LOAD);
   assign wdt_bus.run_en = wdt_ctrl_q[WDT_RUN_BIT];
   assign wdt_bus.rst_en = wdt_ctrl_q[WDT_RSTEN_BIT];
   assign wdt_bus.int_clr = REG_WR && (REG_ADDR == OFS_WDT_ICLR);

   // Two flip-flops for every asynchronous monitor input.
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         meta_q <= 4'h3;
         sync_q <= 4'h3;
      end else begin
         meta_q <= {REG_LOSS, BOR_DET, POR_DET, EXT_RST_N};
         sync_q <= meta_q;
      end
   end

   assign ext_on = ~sync_q[0];
   assign por_on = sync_q[1] & ~por_done_q;
   assign bor_in = sync_q[2];

   // Brown-out acts now, or after the resample delay if still present.
   assign bo_act = ((bo_q == BO_IDLE) && bor_in &&
                    !bo_ctrl_q[BO_RESAMPLE_BIT]) ||
                   ((bo_q == BO_RESAMPLE) && bor_in &&
                    (bo_cnt_q[BO_DELAY_W-1:0] ==
                     bo_ctrl_q[BO_DELAY_LSB +: BO_DELAY_W]));
   assign bor_rst = bo_act && bo_ctrl_q[BO_RESET_BIT];
   assign reg_rst = sync_q[3] && reg_ctrl_q[REG_FAIL_RST_BIT];
   assign int_req = bor_rst | reg_rst | wdt_bus.rst_req | sys_req_q;
   assign taking = rst_n_q && int_req && !ext_on;

   // Cause bits for the internal sources taken this cycle.
   always_comb begin
      cause_set = '0;
      cause_set[CAUSE_BOR] = taking && bor_rst;
      cause_set[CAUSE_WDT] = taking && wdt_bus.rst_req;
      cause_set[CAUSE_SW] = taking && sys_req_q;
      cause_set[CAUSE_REG] = taking && reg_rst;
   end

   // Interrupt events: brown-out without reset, regulator loss, watchdog.
   always_comb begin
      irq_evt = '0;
      irq_evt[IRQ_BOR] = bo_act && !bo_ctrl_q[BO_RESET_BIT];
      irq_evt[IRQ_REG] = sync_q[3] && !reg_loss_q;
      irq_evt[IRQ_WDT] = wdt_bus.int_flag && !wdt_int_q;
   end

   // Main reset sequencer; the pin overrides every other state.
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         state_q <= ST_PIN_WAIT;
         cnt_q <= '0;
      end else if (ext_on || por_on) begin
         state_q <= ST_PIN_WAIT;
         cnt_q <= '0;
      end else begin
         case (state_q)
            ST_PIN_WAIT: begin
               state_q <= ST_SETTLE;
               cnt_q <= '0;
            end
            ST_SETTLE: begin
               cnt_q <= cnt_q + 20'h0_0001;
               if (cnt_q == SETTLE_LAST) begin
                  state_q <= ST_GET_SP;
               end
            end
            ST_INT_HOLD: begin
               cnt_q <= cnt_q + 20'h0_0001;
               if (cnt_q == INT_HOLD_LAST) begin
                  state_q <= ST_GET_SP;
               end
            end
            ST_GET_SP: state_q <= taking ? ST_INT_HOLD : ST_GET_PC;
            ST_GET_PC: state_q <= taking ? ST_INT_HOLD : ST_GET_INSN;
            ST_GET_INSN: state_q <= taking ? ST_INT_HOLD : ST_RUN;
            ST_RUN: begin
               if (taking) begin
                  state_q <= ST_INT_HOLD;
                  cnt_q <= '0;
               end
            end
            default: state_q <= ST_PIN_WAIT;
         endcase
         if (taking) begin
            cnt_q <= '0;
         end
      end
   end

   // Power-on is honoured once; later monitor pulses are ignored.
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         por_done_q <= 1'b0;
      end else if (state_q == ST_PIN_WAIT && !sync_q[1] && !ext_on) begin
         por_done_q <= 1'b1;
      end
   end

   // Reset outputs come from flops; PERIPH_RST_N leaves reset one cycle after SYS_RST_N.
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         rst_n_q <= 1'b0;
         tap_rst_n_q <= 1'b0;
      end else begin
         rst_n_q <= !ext_on && !por_on && !taking &&
                    (state_q == ST_GET_SP || state_q == ST_GET_PC ||
                     state_q == ST_GET_INSN || state_q == ST_RUN);
         tap_rst_n_q <= por_done_q;
      end
   end

   // Boot fetch order after release: stack, counter, instruction.
   always_ff @(posedge SYS_CLK) begin
      if (!NRST || ext_on || por_on || taking) begin
         fetch_q <= FETCH_NONE;
      end else begin
         case (state_q)
            ST_GET_SP: fetch_q <= FETCH_SP;
            ST_GET_PC: fetch_q <= FETCH_PC;
            ST_GET_INSN: fetch_q <= FETCH_INSN;
            default: fetch_q <= FETCH_NONE;
         endcase
      end
   end

   // Brown-out filter and 500 us lockout before a new detection counts.
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         bo_q <= BO_IDLE;
         bo_cnt_q <= '0;
      end else begin
         case (bo_q)
            BO_IDLE: begin
               bo_cnt_q <= '0;
               if (bor_in) begin
                  bo_q <= bo_act ? BO_HOLD : BO_RESAMPLE;
               end
            end
            BO_RESAMPLE: begin
               bo_cnt_q <= bo_cnt_q + 16'h0001;
               if (bo_cnt_q[BO_DELAY_W-1:0] ==
                   bo_ctrl_q[BO_DELAY_LSB +: BO_DELAY_W]) begin
                  bo_q <= bor_in ? BO_HOLD : BO_IDLE;
                  bo_cnt_q <= '0;
               end
            end
            BO_HOLD: begin
               bo_cnt_q <= bo_cnt_q + 16'h0001;
               if (bo_cnt_q == BOR_HOLD_LAST) begin
                  bo_q <= BO_IDLE;
               end
            end
            default: bo_q <= BO_IDLE;
         endcase
      end
   end

   // Configuration returns to defaults on pin and power-on resets.
   always_ff @(posedge SYS_CLK) begin
      if (!NRST || state_q == ST_PIN_WAIT) begin
         bo_ctrl_q <= BO_CTRL_RESET;
         reg_ctrl_q <= REG_CTRL_RESET;
      end else if (REG_WR && REG_ADDR == OFS_BO_CTRL) begin
         bo_ctrl_q <= {16'h0000, REG_WDATA[15:0]};
      end else if (REG_WR && REG_ADDR == OFS_REG_CTRL) begin
         reg_ctrl_q <= {REG_WDATA[31], 27'h000_0000,
                        clamp_trim(REG_WDATA[3:0])};
      end
   end

   // Peripheral soft resets; bit n of register k drives unit k*32+n.
   always_ff @(posedge SYS_CLK) begin
      if (!NRST || !rst_n_q) begin
         soft_q <= '0;
      end else if (REG_WR) begin
         for (int k = 0; k < SOFT_REGS; k++) begin
            if (REG_ADDR == OFS_SOFT_RST0 + 12'(4 * k)) begin
               soft_q[k*SOFT_W +: SOFT_W] <= REG_WDATA;
            end
         end
      end
   end

   // Every clock domain of a unit sees the same active-low reset.
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         periph_q <= '0;
      end else begin
         periph_q <= ~(soft_q | {(SOFT_REGS*SOFT_W){~rst_n_q}});
      end
   end

   // System reset request and watchdog set-up registers.
   always_ff @(posedge SYS_CLK) begin
      if (!NRST || !rst_n_q) begin
         sys_req_q <= 1'b0;
         wdt_ctrl_q <= 2'h0;
         wdt_load_q <= WDT_LOAD_RESET;
      end else begin
         if (REG_WR && REG_ADDR == OFS_SYS_REQ) begin
            sys_req_q <= REG_WDATA[SYS_REQ_BIT];
         end
         if (REG_WR && REG_ADDR == OFS_WDT_CTRL) begin
            wdt_ctrl_q <= REG_WDATA[1:0];
         end
         if (wdt_bus.load_wr) begin
            wdt_load_q <= REG_WDATA;
         end
      end
   end

   // Cause flags survive internal resets; the pin leaves only its own.
   assign wr_cause = REG_WR && REG_ADDR == OFS_CAUSE;
   assign cause_d = w1c({2'b00, cause_q},
                        wr_cause ? REG_WDATA[7:0] : 8'h00,
                        {2'b00, cause_set});
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         cause_q <= '0;
      end else if (ext_on) begin
         cause_q <= CAUSE_W'(1 << CAUSE_EXT);
      end else if (state_q == ST_PIN_WAIT && !por_done_q && !sync_q[1]) begin
         cause_q <= cause_d[CAUSE_W-1:0] | CAUSE_W'(1 << CAUSE_POR);
      end else begin
         cause_q <= cause_d[CAUSE_W-1:0];
      end
   end

   // Sticky interrupt status, mask and the level output.
   assign wr_irq = REG_WR && REG_ADDR == OFS_IRQ_STATUS;
   assign irq_d = w1c({5'h00, irq_st_q}, wr_irq ? REG_WDATA[7:0] : 8'h00,
                      {5'h00, irq_evt});
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         irq_st_q <= '0;
         irq_mask_q <= '0;
         irq_q <= 1'b0;
         reg_loss_q <= 1'b0;
         wdt_int_q <= 1'b0;
      end else begin
         irq_st_q <= irq_d[IRQ_W-1:0];
         if (REG_WR && REG_ADDR == OFS_IRQ_MASK) begin
            irq_mask_q <= REG_WDATA[IRQ_W-1:0];
         end
         irq_q <= |(irq_st_q & irq_mask_q);
         reg_loss_q <= sync_q[3];
         wdt_int_q <= wdt_bus.int_flag;
      end
   end

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge SYS_CLK) begin
      if (!NRST || !REG_RD) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         case (REG_ADDR)
            OFS_BO_CTRL: rdata_q <= bo_ctrl_q;
            OFS_REG_CTRL: rdata_q <= reg_ctrl_q;
            OFS_SOFT_RST0: rdata_q <= soft_q[31:0];
            OFS_SOFT_RST1: rdata_q <= soft_q[63:32];
            OFS_SOFT_RST2: rdata_q <= soft_q[95:64];
            OFS_IRQ_STATUS: rdata_q <= {29'h0000_0000, irq_st_q};
            OFS_IRQ_MASK: rdata_q <= {29'h0000_0000, irq_mask_q};
            OFS_CAUSE: rdata_q <= {26'h000_0000, cause_q};
            OFS_SYS_REQ: rdata_q <= {31'h0000_0000, sys_req_q};
            OFS_WDT_LOAD: rdata_q <= wdt_load_q;
            OFS_WDT_VALUE: rdata_q <= wdt_bus.count;
            OFS_WDT_CTRL: rdata_q <= {30'h0000_0000, wdt_ctrl_q};
            OFS_WDT_RIS: rdata_q <= {31'h0000_0000, wdt_bus.int_flag};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign REG_RDATA = rdata_q;
   assign SYS_RST_N = rst_n_q;
   assign TAP_RST_N = tap_rst_n_q;
   assign PERIPH_RST_N = periph_q;
   assign FETCH_STEP = fetch_q;
   assign REG_TRIM = reg_ctrl_q[TRIM_LSB +: TRIM_W];
   assign IRQ = irq_q;
endmodule

// file: rst_seq_pkg.sv
// Shared constants and types for the reset source sequencer.
package rst_seq_pkg;
   // Register byte offsets.
   localparam logic [11:0] OFS_BO_CTRL = 12'h030;
   localparam logic [11:0] OFS_REG_CTRL = 12'h034;
   localparam logic [11:0] OFS_SOFT_RST0 = 12'h040;
   localparam logic [11:0] OFS_SOFT_RST1 = 12'h044;
   localparam logic [11:0] OFS_SOFT_RST2 = 12'h048;
   localparam logic [11:0] OFS_IRQ_STATUS = 12'h050;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h054;
   localparam logic [11:0] OFS_CAUSE = 12'h05C;
   localparam logic [11:0] OFS_SYS_REQ = 12'h060;
   localparam logic [11:0] OFS_WDT_LOAD = 12'h100;
   localparam logic [11:0] OFS_WDT_VALUE = 12'h104;
   localparam logic [11:0] OFS_WDT_CTRL = 12'h108;
   localparam logic [11:0] OFS_WDT_ICLR = 12'h10C;
   localparam logic [11:0] OFS_WDT_RIS = 12'h110;
   // Field positions.
   localparam int BO_RESAMPLE_BIT = 0;
   localparam int BO_RESET_BIT = 1;
   localparam int BO_DELAY_LSB = 2;
   localparam int BO_DELAY_W = 14;
   localparam int TRIM_LSB = 0;
   localparam int TRIM_W = 4;
   localparam int REG_FAIL_RST_BIT = 31;
   localparam int SYS_REQ_BIT = 0;
   localparam int WDT_RUN_BIT = 0;
   localparam int WDT_RSTEN_BIT = 1;
   localparam int CAUSE_EXT = 0;
   localparam int CAUSE_POR = 1;
   localparam int CAUSE_BOR = 2;
   localparam int CAUSE_WDT = 3;
   localparam int CAUSE_SW = 4;
   localparam int CAUSE_REG = 5;
   localparam int CAUSE_W = 6;
   localparam int IRQ_BOR = 0;
   localparam int IRQ_REG = 1;
   localparam int IRQ_WDT = 2;
   localparam int IRQ_W = 3;
   localparam int SOFT_REGS = 3;
   localparam int SOFT_W = 32;
   // Reset values.
   localparam logic [31:0] BO_CTRL_RESET = 32'h0000_7FFD;
   localparam logic [31:0] REG_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] WDT_LOAD_RESET = 32'hFFFF_FFFF;
   // Regulator trim range in millivolts.
   localparam int TRIM_BASE_MV = 2250;
   localparam int TRIM_TOP_MV = 2750;
   localparam int TRIM_STEP_MV = 50;
   localparam logic [3:0] TRIM_MAX =
      4'((TRIM_TOP_MV - TRIM_BASE_MV) / TRIM_STEP_MV);
   // Timing, derived from the 25 MHz system clock.
   localparam int CLK_MHZ = 25;
   localparam int SETTLE_TIME_MS = 15;
   localparam int SETTLE_CYCLES = SETTLE_TIME_MS * 1000 * CLK_MHZ;
   localparam int BOR_HOLD_TIME_US = 500;
   localparam int BOR_HOLD_CYCLES = BOR_HOLD_TIME_US * CLK_MHZ;
   localparam int INT_HOLD_TIME_NS = 320;
   localparam int INT_HOLD_CYCLES = (INT_HOLD_TIME_NS * CLK_MHZ + 999) / 1000;
   // Fetch step codes shown to the core.
   localparam logic [1:0] FETCH_NONE = 2'h0;
   localparam logic [1:0] FETCH_SP = 2'h1;
   localparam logic [1:0] FETCH_PC = 2'h2;
   localparam logic [1:0] FETCH_INSN = 2'h3;
   typedef enum logic [2:0] {
      ST_PIN_WAIT, ST_SETTLE, ST_INT_HOLD, ST_GET_SP, ST_GET_PC,
      ST_GET_INSN, ST_RUN
   } seq_state_type;
   typedef enum logic [1:0] {BO_IDLE, BO_RESAMPLE, BO_HOLD} bo_state_type;
endpackage

// file: supply_monitor_model.sv
// Model of the reset pin and the on-chip supply monitors.
`timescale 1ns/1ns
module supply_monitor_model (
   // Clock for pacing.
   input wire logic SYS_CLK,
   // Lines into the sequencer.
   output logic EXT_RST_N,
   output logic POR_DET,
   output logic BOR_DET,
   output logic REG_LOSS
);
   // Pin rests high on its pull-up; power-on starts active.
   initial begin
      EXT_RST_N = 1'b1;
      POR_DET = 1'b1;
      BOR_DET = 1'b0;
      REG_LOSS = 1'b0;
   end
   // Power-on pulse ends once and never comes back.
   task automatic power_up(input int n);
      repeat (n) @(posedge SYS_CLK);
      POR_DET <= 1'b0;
   endtask
   task automatic pin_pulse(input int n);
      EXT_RST_N <= 1'b0;
      repeat (n) @(posedge SYS_CLK);
      EXT_RST_N <= 1'b1;
   endtask
   task automatic bor_pulse(input int n);
      BOR_DET <= 1'b1;
      repeat (n) @(posedge SYS_CLK);
      BOR_DET <= 1'b0;
   endtask
   task automatic loss_pulse(input int n);
      REG_LOSS <= 1'b1;
      repeat (n) @(posedge SYS_CLK);
      REG_LOSS <= 1'b0;
   endtask
endmodule

// file: tb_top.sv
// Self-checking bench for the reset source sequencer.
`timescale 1ns/1ns
module tb_top;
   import rst_seq_pkg::*;
   logic SYS_CLK = 1'b0;
   logic NRST, REG_WR, REG_RD;
   logic [11:0] REG_ADDR;
   logic EXT_RST_N, POR_DET, BOR_DET, REG_LOSS, SYS_RST_N, TAP_RST_N, IRQ;
   logic [31:0] REG_RDATA, REG_WDATA, cause, v;
   logic [SOFT_REGS*SOFT_W-1:0] PERIPH_RST_N;
   logic [1:0] FETCH_STEP;
   logic [3:0] REG_TRIM;
   logic [31:0] exp_q[$];
   logic rd_d = 1'b0;
   logic [31:0] rnd_q = 32'h0000_0034;
   int errors = 0;
   int n_compared = 0;
   // Short counts keep the run brief.
   reset_source_sequencer #(.SETTLE_COUNT(20), .BOR_HOLD_COUNT(16))
   reset_source_sequencer_inst (.SYS_CLK(SYS_CLK), .NRST(NRST),
      .EXT_RST_N(EXT_RST_N), .POR_DET(POR_DET), .BOR_DET(BOR_DET),
      .REG_LOSS(REG_LOSS), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
      .SYS_RST_N(SYS_RST_N), .TAP_RST_N(TAP_RST_N),
      .PERIPH_RST_N(PERIPH_RST_N), .FETCH_STEP(FETCH_STEP),
      .REG_TRIM(REG_TRIM), .IRQ(IRQ));
   supply_monitor_model supply_monitor_model_inst (.SYS_CLK(SYS_CLK),
      .EXT_RST_N(EXT_RST_N), .POR_DET(POR_DET), .BOR_DET(BOR_DET),
      .REG_LOSS(REG_LOSS));
   // Clock of 40 ns period.
   always #20 SYS_CLK = ~SYS_CLK;
   function automatic logic [31:0] xs();
      rnd_q ^= rnd_q << 13;
      rnd_q ^= rnd_q >> 17;
      rnd_q ^= rnd_q << 5;
      return rnd_q;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Idle cycle after each strobe so no signal is set twice at one edge.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge SYS_CLK);
      REG_WR <= 1'b0;
      @(posedge SYS_CLK);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge SYS_CLK);
      REG_RD <= 1'b0;
      @(posedge SYS_CLK);
   endtask
   // Read data stand only in the cycle after the strobe.
   always @(posedge SYS_CLK) rd_d <= REG_RD;
   always @(negedge SYS_CLK) begin
      if (rd_d) begin
         check(REG_RDATA, exp_q.pop_front());
      end
   end
   task automatic boot(input int lim);
      int i;
      i = 0;
      @(negedge SYS_CLK);
      while (FETCH_STEP !== FETCH_SP && i < lim) begin
         @(negedge SYS_CLK);
         i++;
      end
      check(FETCH_STEP, FETCH_SP);
      @(negedge SYS_CLK);
      check(FETCH_STEP, FETCH_PC);
      @(negedge SYS_CLK);
      check(FETCH_STEP, FETCH_INSN);
      check(SYS_RST_N, 1'b1);
      @(posedge SYS_CLK);
   endtask
   task automatic tally_and_finish();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // About sixty times the expected run length means a hang.
   initial begin
      repeat (20000) @(posedge SYS_CLK);
      errors++;
      tally_and_finish();
   end
   initial begin
      NRST <= 1'b0;
      REG_WR <= 1'b0;
      REG_RD <= 1'b0;
      repeat (20) @(posedge SYS_CLK);
      NRST <= 1'b1;
      supply_monitor_model_inst.power_up(5);
      boot(100);
      check(TAP_RST_N, 1'b1);
      cause = 32'h0000_0001 << CAUSE_POR;
      rd(OFS_CAUSE, cause);
      rd(OFS_BO_CTRL, BO_CTRL_RESET);
      rd(OFS_REG_CTRL, REG_CTRL_RESET);
      rd(12'h0FC, 32'h0000_0000);
      wr(OFS_REG_CTRL, 32'h0000_000F);
      rd(OFS_REG_CTRL, 32'(TRIM_MAX));
      check(REG_TRIM, TRIM_MAX);
      for (int k = 0; k < SOFT_REGS; k++) begin
         v = xs();
         wr(OFS_SOFT_RST0 + 12'(4 * k), v);
         rd(OFS_SOFT_RST0 + 12'(4 * k), v);
         check(PERIPH_RST_N[k*SOFT_W +: SOFT_W], ~v);
         wr(OFS_SOFT_RST0 + 12'(4 * k), 32'h0000_0000);
      end
      // Brown-out with reset off: masked, then unmasked, then cleared.
      wr(OFS_BO_CTRL, 32'h0000_0000);
      check(&PERIPH_RST_N, 1'b1);
      wr(OFS_IRQ_MASK, 32'h0000_0000);
      supply_monitor_model_inst.bor_pulse(4);
      repeat (16) @(posedge SYS_CLK);
      check(IRQ, 1'b0);
      check(SYS_RST_N, 1'b1);
      rd(OFS_IRQ_STATUS, 32'h0000_0001 << IRQ_BOR);
      wr(OFS_IRQ_MASK, 32'h0000_0007);
      repeat (2) @(posedge SYS_CLK);
      check(IRQ, 1'b1);
      wr(OFS_IRQ_STATUS, 32'h0000_0001);
      repeat (2) @(posedge SYS_CLK);
      check(IRQ, 1'b0);
      wr(OFS_SYS_REQ, 32'h0000_0001);
      boot(50);
      cause |= 32'h0000_0001 << CAUSE_SW;
      rd(OFS_CAUSE, cause);
      // Resample after 10 cycles: a glitch is dropped, a long dip resets.
      wr(OFS_BO_CTRL, 32'h0000_002B);
      supply_monitor_model_inst.bor_pulse(2);
      repeat (30) @(posedge SYS_CLK);
      check(SYS_RST_N, 1'b1);
      supply_monitor_model_inst.bor_pulse(16);
      boot(80);
      cause |= 32'h0000_0001 << CAUSE_BOR;
      rd(OFS_CAUSE, cause);
      wr(OFS_REG_CTRL, 32'h8000_0003);
      supply_monitor_model_inst.loss_pulse(4);
      boot(60);
      cause |= 32'h0000_0001 << CAUSE_REG;
      rd(OFS_CAUSE, cause);
      wr(OFS_WDT_LOAD, 32'h0000_0028);
      wr(OFS_WDT_CTRL, 32'h0000_0003);
      boot(300);
      cause |= 32'h0000_0001 << CAUSE_WDT;
      rd(OFS_CAUSE, cause);
      supply_monitor_model_inst.pin_pulse(5);
      check(TAP_RST_N, 1'b1);
      check(SYS_RST_N, 1'b0);
      boot(100);
      rd(OFS_CAUSE, 32'h0000_0001 << CAUSE_EXT);
      wr(OFS_CAUSE, 32'h0000_0001);
      rd(OFS_CAUSE, 32'h0000_0000);
      tally_and_finish();
   end
endmodule
bind reset_source_sequencer reset_seq_checker #(
   .SETTLE_COUNT(SETTLE_COUNT), .BOR_HOLD_COUNT(BOR_HOLD_COUNT))
reset_seq_checker_inst (.SYS_CLK(SYS_CLK), .NRST(NRST),
   .EXT_RST_N(EXT_RST_N), .POR_DET(POR_DET), .BOR_DET(BOR_DET),
   .REG_LOSS(REG_LOSS), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
   .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
   .SYS_RST_N(SYS_RST_N), .TAP_RST_N(TAP_RST_N),
   .PERIPH_RST_N(PERIPH_RST_N), .FETCH_STEP(FETCH_STEP),
   .REG_TRIM(REG_TRIM), .IRQ(IRQ));

// file: wdt_core.sv
// Two-stage watchdog: interrupt on first time-out, reset on second.
`timescale 1ns/1ns
module wdt_core
   import rst_seq_pkg::*;
(
   // Clock and resets.
   input wire logic clk,
   input wire logic nrst,
   input wire logic hold,
   // Control from the sequencer.
   wdt_ctl_if.wdt ctl
);
   logic [31:0] count_q;
   logic int_q;
   logic rst_q;
   logic zero;

   assign zero = (count_q == 32'h0000_0000);
   assign ctl.count = count_q;
   assign ctl.int_flag = int_q;
   assign ctl.rst_req = rst_q;

   // Count down; every zero reloads from the load value.
   always_ff @(posedge clk) begin
      if (!nrst || hold) begin
         count_q <= WDT_LOAD_RESET;
      end else if (ctl.load_wr) begin
         count_q <= ctl.load_val;
      end else if (ctl.run_en) begin
         count_q <= zero ? ctl.load_val : count_q - 32'h0000_0001;
      end
   end

   // First time-out raises the interrupt; a set beats a clear.
   always_ff @(posedge clk) begin
      if (!nrst || hold) begin
         int_q <= 1'b0;
      end else if (ctl.run_en && zero) begin
         int_q <= 1'b1;
      end else if (ctl.int_clr) begin
         int_q <= 1'b0;
      end
   end

   // Second time-out with the interrupt still pending asks for reset.
   always_ff @(posedge clk) begin
      if (!nrst || hold) begin
         rst_q <= 1'b0;
      end else begin
         rst_q <= ctl.run_en && zero && int_q && ctl.rst_en;
      end
   end
endmodule

// file: wdt_ctl_if.sv
// Control and status bundle between the sequencer and its watchdog.
`timescale 1ns/1ns
interface wdt_ctl_if;
   logic [31:0] load_val;
   logic load_wr;
   logic run_en;
   logic rst_en;
   logic int_clr;
   logic [31:0] count;
   logic int_flag;
   logic rst_req;
   modport ctl (output load_val, load_wr, run_en, rst_en, int_clr,
                input count, int_flag, rst_req);
   modport wdt (input load_val, load_wr, run_en, rst_en, int_clr,
                output count, int_flag, rst_req);
endinterface
